// ==== hw/pacer_trigger.sv ====
// Overview of operation
// - three 16-bit counters, two and three on 10 MHz base
// - counter one counts input event pulses
// - counters two and three chain into 32 bits
// - pacer output rising edge starts conversion
// - pacer output driven out on a pin
// - gate high enables external triggering
// - external clock rising edge starts conversion
// - gate low disables external triggering
`timescale 1ns/1ps
module pacer_trigger
   import pacer_pkg::*;
#(
   parameter int WIDTH = CNT_W
)
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   // host loads counter divisors when the strobe is high
   input wire logic load_in,
   input wire logic [WIDTH-1:0] event_div_in,
   input wire logic [WIDTH-1:0] pacer_lo_div_in,
   input wire logic [WIDTH-1:0] pacer_hi_div_in,
   // event pulses for the first counter, one system cycle each
   input wire logic event_pulse_in,
   input wire logic external_trigger_gate_in,
   input wire logic external_trigger_clock_in,
   output logic [WIDTH-1:0] event_count_out,
   output logic event_done_out,
   output logic pacer_out,
   output logic gate_enabled_out,
   output logic convert_start_out
);
   // every register of the block
   typedef struct packed
   {
      logic [1:0] div;
      logic [WIDTH-1:0] ev_cnt;
      logic [WIDTH-1:0] ev_div;
      logic ev_done;
      logic [WIDTH-1:0] lo_cnt;
      logic [WIDTH-1:0] lo_div;
      logic [WIDTH-1:0] hi_cnt;
      logic [WIDTH-1:0] hi_div;
      pacer_phase_t phase;
      logic pacer_d;
      logic [1:0] gate_sync;
      logic [1:0] clk_sync;
      logic clk_d;
      logic start;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // count a reload style down counter; returns next value
   function automatic logic [WIDTH-1:0] count_down(input logic [WIDTH-1:0] v,
                                                   input logic [WIDTH-1:0] d);
      begin
         if (v <= CNT_ONE[WIDTH-1:0])
         begin
            count_down = d;
         end
         else
         begin
            count_down = v - CNT_ONE[WIDTH-1:0];
         end
      end
   endfunction

   logic tick; // one 10 MHz base tick
   logic lo_wrap; // low pacer stage finished a period
   logic pacer_rise; // rising edge of pacer output
   logic ext_rise; // synced external clock rising edge

   // next-state logic
   always_comb
   begin
      st_nxt = st_r;
      tick = (st_r.div == DIV_LAST);
      st_nxt.div = tick ? 2'b00 : st_r.div + 2'b01;
      // done is a one-cycle pulse: low unless this pulse wraps the count
      st_nxt.ev_done = 1'b0;
      // event counter counts pulses up to the divisor
      if (event_pulse_in)
      begin
         if (st_r.ev_cnt + CNT_ONE[WIDTH-1:0] >= st_r.ev_div)
         begin
            st_nxt.ev_cnt = CNT_ZERO[WIDTH-1:0];
            st_nxt.ev_done = 1'b1;
         end
         else
         begin
            st_nxt.ev_cnt = st_r.ev_cnt + CNT_ONE[WIDTH-1:0];
         end
      end
      // chained pacer: low stage clocks the high stage
      lo_wrap = tick && (st_r.lo_cnt <= CNT_ONE[WIDTH-1:0]);
      if (tick)
      begin
         st_nxt.lo_cnt = count_down(st_r.lo_cnt, st_r.lo_div);
      end
      if (lo_wrap)
      begin
         st_nxt.hi_cnt = count_down(st_r.hi_cnt, st_r.hi_div);
         // square wave: high for first half of the high-stage count
         if (st_r.hi_cnt <= CNT_ONE[WIDTH-1:0])
         begin
            st_nxt.phase = PH_HIGH;
         end
         else if (st_r.hi_cnt == (st_r.hi_div >> 1) + CNT_ONE[WIDTH-1:0])
         begin
            st_nxt.phase = PH_LOW;
         end
      end
      // host reload restarts all counters
      if (load_in)
      begin
         st_nxt.ev_div = event_div_in;
         st_nxt.lo_div = pacer_lo_div_in;
         st_nxt.hi_div = pacer_hi_div_in;
         st_nxt.ev_cnt = CNT_ZERO[WIDTH-1:0];
         st_nxt.lo_cnt = pacer_lo_div_in;
         st_nxt.hi_cnt = pacer_hi_div_in;
         st_nxt.phase = PH_LOW;
      end
      st_nxt.pacer_d = (st_r.phase == PH_HIGH);
      pacer_rise = (st_r.phase == PH_HIGH) && !st_r.pacer_d;
      // two-flop synchronisers; only stage 2 (bit 1) is looked at
      st_nxt.gate_sync = {st_r.gate_sync[0], external_trigger_gate_in};
      st_nxt.clk_sync = {st_r.clk_sync[0], external_trigger_clock_in};
      st_nxt.clk_d = st_r.clk_sync[1];
      // gate high enables, gate low masks edges
      ext_rise = st_r.gate_sync[1] && st_r.clk_sync[1] && !st_r.clk_d;
      st_nxt.start = pacer_rise || ext_rise;
   end

   // state register, synchronous reset
   always_ff @(posedge clk_in)
   begin
      if (!reset_n_in)
      begin
         st_r <= '0;
         // divisors and counts return to their defaults
         st_r.ev_div <= PACER_LO_RST[WIDTH-1:0];
         st_r.lo_div <= PACER_LO_RST[WIDTH-1:0];
         st_r.hi_div <= PACER_HI_RST[WIDTH-1:0];
         st_r.lo_cnt <= PACER_LO_RST[WIDTH-1:0];
         st_r.hi_cnt <= PACER_HI_RST[WIDTH-1:0];
         st_r.phase <= PH_LOW;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops
   assign event_count_out = st_r.ev_cnt;
   assign event_done_out = st_r.ev_done;
   assign pacer_out = st_r.pacer_d;
   assign gate_enabled_out = st_r.gate_sync[1];
   assign convert_start_out = st_r.start;

   // a start comes in the same cycle as every pacer pin rise
   a_pacer_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      $rose(pacer_out) |-> convert_start_out)
      else $error("pacer rise gave no start");

   // gate low blocks external-only starts
   a_gate_blocks: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (!st_r.gate_sync[1] && !pacer_rise) |=> !convert_start_out)
      else $error("start while gate low");

   // synced clock edge under gate gives a start
   a_ext_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      ext_rise |=> convert_start_out)
      else $error("external edge lost");

   // base tick every four system clocks
   a_base_tick: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      tick |=> !tick [*3] ##1 tick)
      else $error("base tick spacing wrong");

   // low stage moves only on a tick or a host load
   a_lo_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (!tick && !load_in) |=> $stable(st_r.lo_cnt))
      else $error("low stage moved off tick");

   // gate enable follows pin after two cycles
   a_gate_sync: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      ##2 gate_enabled_out == $past(external_trigger_gate_in, 2))
      else $error("gate sync latency wrong");

   // event count advances by one per pulse
   a_event_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (!load_in && event_pulse_in && event_count_out + 16'h0001 < st_r.ev_div)
      |=> event_count_out == $past(event_count_out) + 16'h0001)
      else $error("event count did not step");

   // pacer pin matches phase one cycle later
   a_pacer_pin: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (st_r.phase == PH_HIGH) |=> pacer_out)
      else $error("pacer pin stale");

   // terminal pulse wraps the count and raises done
   a_event_done: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (event_pulse_in && event_count_out + CNT_ONE[WIDTH-1:0] >= st_r.ev_div)
      |=> (event_done_out && event_count_out == CNT_ZERO[WIDTH-1:0]))
      else $error("event count did not wrap");

   // done never rises without a pulse just before it
   a_done_cause: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      event_done_out |-> $past(event_pulse_in))
      else $error("done without event pulse");

   // host reload restarts the pacer low and clears the count
   a_load_restart: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      load_in |=> (st_r.phase == PH_LOW && event_count_out == CNT_ZERO[WIDTH-1:0]))
      else $error("reload did not restart counters");

   // a start always comes from a pacer or gated external edge
   a_start_cause: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      convert_start_out |-> ($past(pacer_rise) || $past(ext_rise)))
      else $error("start with no cause");
endmodule

// ==== inc/pacer_pkg.sv ====
package pacer_pkg;
   // counter geometry
   localparam int CNT_W = 16;
   // base clock rate feeding the counters, in hz
   localparam int BASE_CLK_HZ = 10000000;
   // system clock rate, in hz
   localparam int SYS_CLK_HZ = 40000000;
   // system clocks per base clock tick
   localparam int BASE_DIV = SYS_CLK_HZ / BASE_CLK_HZ;
   localparam logic [1:0] DIV_LAST = 2'(BASE_DIV - 1);
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   // reset divisors: counters load these until the host writes others
   localparam logic [15:0] PACER_LO_RST = 16'h0002;
   localparam logic [15:0] PACER_HI_RST = 16'h0002;
   // square-wave pacer phase states, gray coded
   typedef enum logic [1:0]
   {
      PH_LOW = 2'b00,
      PH_HIGH = 2'b01
   } pacer_phase_t;
endpackage

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
   import pacer_pkg::*;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic load_in = 1'b0;
   logic event_pulse_in = 1'b0;
   logic [15:0] ev_div = 16'h0002;
   logic [15:0] lo_div = 16'h0002;
   logic [15:0] hi_div = 16'h0002;
   logic gate, external_trigger_clock, pacer_out, gate_en, conv, done;
   logic [15:0] count;
   int conv_count, done_count = 0, err_count = 0, cmp_count = 0, n, d, c0;
   initial forever #12.5 clk_in = ~clk_in;
   pacer_trigger u_pacer_trigger (.clk_in(clk_in), .reset_n_in(reset_n_in), .load_in(load_in),
      .event_div_in(ev_div), .pacer_lo_div_in(lo_div), .pacer_hi_div_in(hi_div),
      .event_pulse_in(event_pulse_in), .external_trigger_gate_in(gate),
      .external_trigger_clock_in(external_trigger_clock), .event_count_out(count), .event_done_out(done),
      .pacer_out(pacer_out), .gate_enabled_out(gate_en), .convert_start_out(conv));
   trig_partner u_trig_partner (.clk_in(clk_in), .convert_start_in(conv), .gate_out(gate),
      .external_trigger_clock_out(external_trigger_clock), .conv_count_out(conv_count));
   // tally event-done pulses
   always @(posedge clk_in)
      if (done === 1'b1)
         done_count <= done_count + 1;
   // expected pacer period in system cycles
   function automatic int period(input int l, input int h);
      return BASE_DIV * l * h;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   task automatic load(input logic [15:0] e, input logic [15:0] l, input logic [15:0] h);
      @(posedge clk_in);
      ev_div <= e;
      lo_div <= l;
      hi_div <= h;
      load_in <= 1'b1;
      @(posedge clk_in);
      load_in <= 1'b0;
   endtask
   // cycles until pacer_out next rises, bounded
   task automatic wait_rise(output int k);
      logic prev;
      k = 0;
      prev = pacer_out;
      while (!(pacer_out === 1'b1 && prev === 1'b0) && k < 2000)
      begin
         prev = pacer_out;
         step(1);
         k++;
      end
   endtask
   initial
   begin
      void'($urandom(38));
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      step(2);
      check("outputs after reset", {pacer_out, conv, gate_en, done, count}, 32'h0);
      $display("test reset done");
      // pacer: random stage divisors, measure period and start latency
      for (int i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 2 : 2 + $urandom % 4;
         n = 2 + $urandom % 4;
         load(16'h0002, 16'(d), 16'(n));
         wait_rise(c0);
         check("start with pacer rise", conv, 1'b1);
         step(1);
         check("start is one cycle", conv, 1'b0);
         wait_rise(c0);
         check("pacer period", c0 + 1, period(d, n));
      end
      $display("test pacer done");
      // event counter: count to terminal, then wrap
      d = 2 + $urandom % 5;
      load(16'(d), 16'hFFFF, 16'hFFFF);
      c0 = done_count;
      for (int i = 1; i <= d; i++)
      begin
         @(posedge clk_in);
         event_pulse_in <= 1'b1;
         @(posedge clk_in);
         event_pulse_in <= 1'b0;
         #1;
         check("event count", count, 32'(i % d));
         check("event done", done, 32'(i == d));
      end
      step(3);
      check("event done pulses", done_count - c0, 1);
      check("event count wrapped", count, 16'h0000);
      $display("test event done");
      // external trigger with gate high, then ignored with gate low
      u_trig_partner.set_gate(1'b1);
      step(4);
      check("gate enabled", gate_en, 1'b1);
      c0 = conv_count;
      n = 1 + $urandom % 5;
      u_trig_partner.send_edges(n, 2 + $urandom % 3);
      step(6);
      check("external starts", conv_count - c0, n);
      u_trig_partner.set_gate(1'b0);
      step(4);
      check("gate disabled", gate_en, 1'b0);
      c0 = conv_count;
      u_trig_partner.send_edges(3, 2);
      step(6);
      check("edges ignored", conv_count - c0, 0);
      $display("test external done");
      give_verdict();
   end
   // watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      give_verdict();
   end
endmodule

// ==== test/trig_partner.sv ====
`timescale 1ns/1ps
// far side: trigger source pins plus a tally of conversion starts
module trig_partner
(
   input wire logic clk_in,
   input wire logic convert_start_in,
   output logic gate_out,
   output logic external_trigger_clock_out,
   output int conv_count_out
);
   initial
   begin
      gate_out = 1'b0;
      external_trigger_clock_out = 1'b0;
      conv_count_out = 0;
   end
   // count each conversion start pulse
   always @(posedge clk_in)
      if (convert_start_in === 1'b1)
         conv_count_out <= conv_count_out + 1;
   // gate: high enables, driven low disables
   task automatic set_gate(input logic lvl);
      @(posedge clk_in);
      gate_out <= lvl;
   endtask
   // n rising edges, each level held for hold cycles
   task automatic send_edges(input int n, input int hold);
      repeat (n)
      begin
         repeat (hold) @(posedge clk_in);
         external_trigger_clock_out <= 1'b1;
         repeat (hold) @(posedge clk_in);
         external_trigger_clock_out <= 1'b0;
      end
   endtask
endmodule
